/* File: hdl/ldc_gate.v */
// Per-switch gating of the power stage drive with shoot-through guard
`default_nettype none
`include "ldc_regs.vh"

module ldc_gate (
    input  wire                          clk_i,
    input  wire                          reset_i,
    input  wire                          enable_i,
    input  wire [`LDC_SWITCH_COUNT-1:0]  request_i,
    input  wire [`LDC_SWITCH_COUNT-1:0]  allow_i,
    output reg  [`LDC_STAGE_COUNT-1:0]   low_side_switch_o,
    output reg  [`LDC_STAGE_COUNT:0]     high_side_switch_o
);

    // Request bit k maps to command bit k+1: even k below 10 low side, odd k and k=10 high side
    wire [`LDC_SWITCH_COUNT-1:0] granted;
    assign granted = request_i & allow_i;

    genvar s;
    generate
        for (s = 0; s < `LDC_STAGE_COUNT; s = s + 1) begin : g_stage
            // Both requested: neither conducts, no path from supply to ground
            wire clash;
            assign clash = request_i[2*s] & request_i[2*s+1]; // RULE3
            always @(posedge clk_i or posedge reset_i) begin
                if (reset_i) begin
                    low_side_switch_o[s]  <= 1'b0;
                    high_side_switch_o[s] <= 1'b0;
                end else if (enable_i) begin
                    low_side_switch_o[s]  <= granted[2*s] & ~clash; // RULE1 RULE2
                    high_side_switch_o[s] <= granted[2*s+1] & ~clash; // RULE1 RULE2
                end
            end
        end
    endgenerate

    // Output 6 has only a highside switch
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            high_side_switch_o[`LDC_STAGE_COUNT] <= 1'b0;
        end else if (enable_i) begin
            high_side_switch_o[`LDC_STAGE_COUNT] <= granted[`LDC_SWITCH_COUNT-1]; // RULE1
        end
    end

endmodule

`default_nettype wire

/* File: hdl/ldc_regs.vh */
// Constants for the load driver command and status word block
`ifndef LDC_REGS_VH
`define LDC_REGS_VH

// ****************************************
// Word geometry
// ****************************************
`define LDC_WORD_BITS        16
`define LDC_COUNT_BITS       5
`define LDC_SWITCH_COUNT     11
`define LDC_STAGE_COUNT      5

// ****************************************
// Command word fields
// ****************************************
`define LDC_CMD_SEL_BIT      0
`define LDC_CMD_SW_LSB       1
`define LDC_CMD_SW_MSB       11
`define LDC_CMD_MON_LSB      12
`define LDC_CMD_MON_MSB      13
`define LDC_CMD_LOCK_BIT     14
`define LDC_CMD_CLEAR_BIT    15
`define LDC_CMD_RESET        16'h0000

// ****************************************
// Monitor codes
// ****************************************
`define LDC_MON_STANDBY      2'h0
`define LDC_MON_POWER_OUTPUT_1         2'h1
`define LDC_MON_POWER_OUTPUT_2         2'h2
`define LDC_MON_POWER_OUTPUT_6         2'h3

// ****************************************
// Status word fields
// ****************************************
`define LDC_ST_FAULT_BIT     0
`define LDC_ST_SW_LSB        1
`define LDC_ST_SW_MSB        11
`define LDC_ST0_THERM_BIT    12
`define LDC_ST0_UNDER_BIT    13
`define LDC_ST0_OVER_BIT     14
`define LDC_ST1_WARN_BIT     12
`define LDC_ST1_PUMP_BIT     13
`define LDC_ST1_UNUSED_BIT   14
`define LDC_ST_MARK_BIT      15
`define LDC_STATUS_RESET     11'h000

// ****************************************
// Timing
// ****************************************
`define LDC_CLK_MHZ          50
`define LDC_WAKE_US          200
`define LDC_SYNC_LAT         16'h0005
`define LDC_WAKE_BITS        16

`endif

/* File: hdl/ldc_sync.v */
// Two flip-flop synchroniser for a group of asynchronous inputs
`default_nettype none

module ldc_sync #(
    parameter             WIDTH = 1,
    parameter [WIDTH-1:0] IDLE  = {WIDTH{1'b0}}
) (
    input  wire             clk_i,
    input  wire             reset_i,
    input  wire             enable_i,
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] stage_one;

    // First stage feeds only the second stage
    // Reset to the idle level, so no false edge follows reset
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            stage_one <= IDLE;
            sync_o    <= IDLE;
        end else if (enable_i) begin
            stage_one <= async_i;
            sync_o    <= stage_one;
        end
    end

endmodule

`default_nettype wire

/* File: hdl/ldc_top.v */
// Command word, status words and serial link of the load driver control block
//
// Notes on behaviour
// [RULE1] Command bits 1-11 drive the eleven power switches, low then high per output.
// [RULE2] A one switches on; status bits read one while their condition holds.
// [RULE3] Both switches of one stage requested: neither is allowed to conduct.
// [RULE4] Status bit 0 is the NOR of bits 1-14 of both status words.
// [RULE5] Fault bit appears on the serial output as soon as select goes low.
// [RULE6] Bit 15 of every returned word is constantly high.
// [RULE7] Status word 0 bits 1-11 flag overcurrent per switch, command bit order.
// [RULE8] Status word 1 bits 1-11 flag open load per switch, command bit order.
// [RULE9] Word 0: overvoltage 14, undervoltage 13, thermal 12; word 1: pump 13, warn 12.
// [RULE10] Leaving standby, drivers enable within 200 us of select rising.
// [RULE11] Command bit 0 picks the status word returned in the same transfer.
// [RULE12] Monitor bits both zero give standby: data cleared, outputs floating.
// [RULE13] Lockout bit set: supply faults block all drivers until flags cleared.
// [RULE14] Command bit 15 clears the status flags when select rises.
// [RULE15] Active monitor code 01, 10, 11 routes output 1, 2, 6.
`default_nettype none
`include "ldc_regs.vh"

module ldc_top #(
    parameter WAKE_CYCLES = `LDC_WAKE_US * `LDC_CLK_MHZ
) (
    input  wire                          clk_i,
    input  wire                          reset_i,
    input  wire                          enable_i,
    input  wire                          serial_clock_i,
    input  wire                          chip_select_low_i,
    input  wire                          serial_input_i,
    output reg                           serial_output_o,
    output wire                          serial_output_oe_o,
    input  wire [`LDC_SWITCH_COUNT-1:0]  overcurrent_i,
    input  wire [`LDC_SWITCH_COUNT-1:0]  open_load_i,
    input  wire                          supply_over_i,
    input  wire                          supply_under_i,
    input  wire                          thermal_shutdown_i,
    input  wire                          thermal_warning_i,
    input  wire                          charge_pump_off_i,
    output wire [`LDC_STAGE_COUNT-1:0]   low_side_switch_o,
    output wire [`LDC_STAGE_COUNT:0]     high_side_switch_o,
    output reg                           outputs_enabled_o,
    output reg  [1:0]                    monitor_select_o,
    output reg                           standby_o
);

    // ****************************************
    // Local constants
    // ****************************************
    localparam NSW   = `LDC_SWITCH_COUNT;
    localparam NWORD = `LDC_WORD_BITS;
    localparam NEV   = 2 * NSW + 5;
    localparam [`LDC_WAKE_BITS-1:0] WAKE_LAST =
        WAKE_CYCLES[`LDC_WAKE_BITS-1:0] - `LDC_SYNC_LAT;
    localparam [`LDC_COUNT_BITS-1:0] FULL_COUNT = NWORD[`LDC_COUNT_BITS-1:0];

    // ****************************************
    // Status word assembly
    // ****************************************
    // Builds either status word; fault bit and marker bit added here
    function [NWORD-1:0] status_word;
        input        sel;
        input [NSW-1:0] oc;
        input [NSW-1:0] ol;
        input        ov;
        input        uv;
        input        ts;
        input        tw;
        input        cp;
        input        no_fault;
        reg   [NWORD-1:0] w;
        begin
            w = {NWORD{1'b0}};
            w[`LDC_ST_MARK_BIT]  = 1'b1; // RULE6
            w[`LDC_ST_FAULT_BIT] = no_fault; // RULE4
            if (!sel) begin
                w[`LDC_ST_SW_MSB:`LDC_ST_SW_LSB] = oc; // RULE7
                w[`LDC_ST0_OVER_BIT]  = ov; // RULE9
                w[`LDC_ST0_UNDER_BIT] = uv; // RULE9
                w[`LDC_ST0_THERM_BIT] = ts; // RULE9
            end else begin
                w[`LDC_ST_SW_MSB:`LDC_ST_SW_LSB] = ol; // RULE8
                w[`LDC_ST1_UNUSED_BIT] = 1'b0; // RULE9
                w[`LDC_ST1_PUMP_BIT]   = cp; // RULE9
                w[`LDC_ST1_WARN_BIT]   = tw; // RULE9
            end
            status_word = w;
        end
    endfunction

    // ****************************************
    // Input synchronisers
    // ****************************************
    wire [2:0]     link_sync;
    wire [NEV-1:0] event_sync;

    // Select idles high; link clock and data idle low
    ldc_sync #(
        .WIDTH    (3),
        .IDLE     (3'h2)
    ) u_link_sync (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .enable_i (enable_i),
        .async_i  ({serial_input_i, chip_select_low_i, serial_clock_i}),
        .sync_o   (link_sync)
    );

    ldc_sync #(
        .WIDTH    (NEV)
    ) u_event_sync (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .enable_i (enable_i),
        .async_i  ({charge_pump_off_i, thermal_warning_i, thermal_shutdown_i,
                    supply_under_i, supply_over_i, open_load_i, overcurrent_i}),
        .sync_o   (event_sync)
    );

    wire           sck      = link_sync[0];
    wire           cs_low_n = link_sync[1];
    wire           din      = link_sync[2];
    wire [NSW-1:0] oc_live  = event_sync[NSW-1:0];
    wire [NSW-1:0] ol_live  = event_sync[2*NSW-1:NSW];
    wire           ov_live  = event_sync[2*NSW];
    wire           uv_live  = event_sync[2*NSW+1];
    wire           ts_live  = event_sync[2*NSW+2];
    wire           tw_live  = event_sync[2*NSW+3];
    wire           cp_live  = event_sync[2*NSW+4];

    // ****************************************
    // Edge detection on the link
    // ****************************************
    reg  sck_prev;
    reg  cs_prev;
    wire sck_rise = sck & ~sck_prev;
    wire sck_fall = ~sck & sck_prev;
    wire cs_fall  = ~cs_low_n & cs_prev;
    wire cs_rise  = cs_low_n & ~cs_prev;

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sck_prev <= 1'b0;
            cs_prev  <= 1'b1;
        end else if (enable_i) begin
            sck_prev <= sck;
            cs_prev  <= cs_low_n;
        end
    end

    // ****************************************
    // Status flags
    // ****************************************
    reg  [NSW-1:0] oc_flag;
    reg  [NSW-1:0] ol_flag;
    reg            ov_flag;
    reg            uv_flag;
    reg            ts_flag;
    reg            tw_flag;
    reg            cp_flag;
    reg  [NWORD-1:0] in_shift;
    reg  [`LDC_COUNT_BITS-1:0] bit_count;

    wire commit     = cs_rise & (bit_count == FULL_COUNT);
    wire new_standby = (in_shift[`LDC_CMD_MON_MSB:`LDC_CMD_MON_LSB] == `LDC_MON_STANDBY);
    // Clear request of the word being committed, or standby entry
    wire flag_clear = commit & (in_shift[`LDC_CMD_CLEAR_BIT] | new_standby); // RULE14 RULE12

    wire no_fault = ~(|{oc_flag, ol_flag, ov_flag, uv_flag, ts_flag,
                        tw_flag, cp_flag}); // RULE4

    // A condition present in the clearing cycle sets the flag again
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            oc_flag <= `LDC_STATUS_RESET;
            ol_flag <= `LDC_STATUS_RESET;
            ov_flag <= 1'b0;
            uv_flag <= 1'b0;
            ts_flag <= 1'b0;
            tw_flag <= 1'b0;
            cp_flag <= 1'b0;
        end else if (enable_i) begin
            oc_flag <= (flag_clear ? {NSW{1'b0}} : oc_flag) | oc_live; // RULE7 RULE14
            ol_flag <= (flag_clear ? {NSW{1'b0}} : ol_flag) | ol_live; // RULE8 RULE14
            ov_flag <= (ov_flag & ~flag_clear) | ov_live; // RULE9 RULE14
            uv_flag <= (uv_flag & ~flag_clear) | uv_live; // RULE9 RULE14
            ts_flag <= (ts_flag & ~flag_clear) | ts_live; // RULE9 RULE14
            tw_flag <= (tw_flag & ~flag_clear) | tw_live; // RULE9 RULE14
            cp_flag <= (cp_flag & ~flag_clear) | cp_live; // RULE9 RULE14
        end
    end

    // ****************************************
    // Serial receive
    // ****************************************
    // LSB first; bits after the sixteenth are ignored
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            in_shift  <= `LDC_CMD_RESET;
            bit_count <= {`LDC_COUNT_BITS{1'b0}};
        end else if (enable_i) begin
            if (cs_low_n) begin
                bit_count <= {`LDC_COUNT_BITS{1'b0}};
            end else if (sck_rise && bit_count != FULL_COUNT) begin
                in_shift[bit_count[3:0]] <= din;
                bit_count                <= bit_count + 1'b1;
            end
        end
    end

    // ****************************************
    // Command word
    // ****************************************
    // Short frames (fault polling) never touch the command word
    reg [NWORD-1:0] command_word;

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            command_word <= `LDC_CMD_RESET;
        end else if (enable_i && commit) begin
            if (new_standby) begin
                command_word <= `LDC_CMD_RESET; // RULE12
            end else begin
                command_word <= in_shift;
            end
        end
    end

    wire [1:0] mon_code = command_word[`LDC_CMD_MON_MSB:`LDC_CMD_MON_LSB];
    wire       active   = (mon_code != `LDC_MON_STANDBY); // RULE12
    wire       lockout  = command_word[`LDC_CMD_LOCK_BIT];

    // ****************************************
    // Serial transmit
    // ****************************************
    reg [NWORD-1:0] out_shift;
    reg             loaded;

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            out_shift       <= {NWORD{1'b0}};
            loaded          <= 1'b0;
            serial_output_o <= 1'b0;
        end else if (enable_i) begin
            if (cs_low_n) begin
                loaded <= 1'b0;
            end else if (sck_rise && !loaded) begin
                // Select bit arrives with this very edge
                out_shift <= status_word(din, oc_flag, ol_flag, ov_flag, uv_flag,
                                         ts_flag, tw_flag, cp_flag, no_fault); // RULE11
                loaded    <= 1'b1;
            end else if (sck_fall && loaded) begin
                out_shift <= {1'b0, out_shift[NWORD-1:1]};
            end
            if (!loaded || cs_fall) begin
                serial_output_o <= no_fault; // RULE5
            end else begin
                serial_output_o <= out_shift[0];
            end
        end
    end

    // Drives only while selected; floats otherwise
    assign serial_output_oe_o = ~cs_low_n; // RULE5

    // ****************************************
    // Wake-up timer
    // ****************************************
    // Pin-to-driver pipeline latency is taken off the count
    reg [`LDC_WAKE_BITS-1:0] wake_count;
    reg                      awake;

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wake_count <= {`LDC_WAKE_BITS{1'b0}};
            awake      <= 1'b0;
        end else if (enable_i) begin
            if (!active) begin
                wake_count <= {`LDC_WAKE_BITS{1'b0}};
                awake      <= 1'b0;
            end else if (!awake) begin
                if (wake_count >= WAKE_LAST) begin
                    awake <= 1'b1; // RULE10
                end else begin
                    wake_count <= wake_count + 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Driver enables
    // ****************************************
    wire supply_bad = lockout ? (ov_flag | uv_flag) : (ov_live | uv_live); // RULE13
    wire global_ok  = awake & ~ts_flag & ~supply_bad;
    // Overcurrent on a switch holds only that switch off until cleared
    wire [NSW-1:0] allow = ~oc_flag & {NSW{global_ok}};

    ldc_gate u_gate (
        .clk_i              (clk_i),
        .reset_i            (reset_i),
        .enable_i           (enable_i),
        .request_i          (command_word[`LDC_CMD_SW_MSB:`LDC_CMD_SW_LSB]), // RULE1
        .allow_i            (allow),
        .low_side_switch_o  (low_side_switch_o),
        .high_side_switch_o (high_side_switch_o)
    );

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            outputs_enabled_o <= 1'b0;
            monitor_select_o  <= `LDC_MON_STANDBY;
            standby_o         <= 1'b1;
        end else if (enable_i) begin
            outputs_enabled_o <= global_ok; // RULE10 RULE12
            monitor_select_o  <= mon_code; // RULE15
            standby_o         <= ~active; // RULE12
        end
    end

endmodule

`default_nettype wire

/* File: verif/ldc_host_model.sv */
// Serial link master model driving the command link, LSB first
`default_nettype none
module ldc_host_model (
    input  wire logic clk_i,
    output var  logic serial_clock_o,
    output var  logic chip_select_low_o,
    output var  logic serial_input_o,
    input  wire logic serial_output_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // Link clock idles low; data line rests at its pull-down level
    initial begin
        serial_clock_o = 1'b0;
        chip_select_low_o = 1'b1;
        serial_input_o = 1'b0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Full frame: 16 rises, clock left high before select rises
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
        step(1);
        chip_select_low_o <= 1'b0;
        step(6);
        rsp[0] = serial_output_i;
        for (int i = 0; i < 16; i++) begin
            serial_input_o <= cmd[i];
            step(4);
            serial_clock_o <= 1'b1;
            step(2);
            if (i > 0)
                rsp[i] = serial_output_i;
            step(2);
            if (i < 15)
                serial_clock_o <= 1'b0;
        end
        chip_select_low_o <= 1'b1;
        serial_input_o <= 1'b0;
        step(4);
        serial_clock_o <= 1'b0;
        step(12);
    endtask
    // Fault poll without clocking the link
    task automatic poll(output logic nf);
        step(1);
        chip_select_low_o <= 1'b0;
        step(6);
        nf = serial_output_i;
        chip_select_low_o <= 1'b1;
        step(6);
    endtask
endmodule
`default_nettype wire

/* File: verif/ldc_top_monitor.sv */
// Port-level assertions for the load driver control block
`default_nettype none
module ldc_top_monitor #(
    parameter WAKE_CYCLES = 10000
) (
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        chip_select_low_i,
    input wire logic        serial_output_oe_o,
    input wire logic [10:0] overcurrent_i,
    input wire logic [4:0]  low_side_switch_o,
    input wire logic [5:0]  high_side_switch_o,
    input wire logic        outputs_enabled_o,
    input wire logic [1:0]  monitor_select_o,
    input wire logic        standby_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WAKE_MAX = WAKE_CYCLES - 4;
    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    // ****************************
    // Checks
    // ****************************
    shoot_guard_a: assert property (
        (low_side_switch_o & high_side_switch_o[4:0]) == 5'h00)
        else $error("both switches of one stage on");
    standby_off_a: assert property (
        standby_o && $past(standby_o, 2) |->
        !outputs_enabled_o && low_side_switch_o == 5'h00 && high_side_switch_o == 6'h00)
        else $error("drive active in standby");
    standby_mon_a: assert property (
        standby_o |-> monitor_select_o == 2'h0)
        else $error("monitor code set in standby");
    oe_follow_a: assert property (
        $changed(chip_select_low_i) |-> ##[1:3] (serial_output_oe_o == !chip_select_low_i))
        else $error("output enable not following select");
    wake_bound_a: assert property (
        $fell(standby_o) |-> ##[0:WAKE_MAX] (outputs_enabled_o || standby_o))
        else $error("drivers not enabled in time");
    mon_commit_a: assert property (
        $changed(monitor_select_o) |-> chip_select_low_i)
        else $error("monitor changed inside a frame");
    drive_enable_a: assert property (
        (|low_side_switch_o || |high_side_switch_o) && !standby_o |->
        ##[0:2] outputs_enabled_o)
        else $error("switch on with drivers disabled");
    oc_cut_a: assert property (
        $rose(overcurrent_i[0]) |-> ##[1:6] !low_side_switch_o[0])
        else $error("overcurrent switch left on");
endmodule
bind ldc_top ldc_top_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) ldc_top_monitor_inst (
    .clk_i(clk_i), .reset_i(reset_i), .chip_select_low_i(chip_select_low_i),
    .serial_output_oe_o(serial_output_oe_o), .overcurrent_i(overcurrent_i),
    .low_side_switch_o(low_side_switch_o), .high_side_switch_o(high_side_switch_o),
    .outputs_enabled_o(outputs_enabled_o), .monitor_select_o(monitor_select_o),
    .standby_o(standby_o));
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the load driver control block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WAKE = 20;
    logic        clk_i;
    logic        reset_i;
    logic [10:0] oc;
    logic [10:0] ol;
    logic [4:0]  sup;
    wire         sclk;
    wire         csl;
    wire         sdi;
    wire         sdo;
    wire         sdo_oe;
    wire         sdo_line;
    wire  [4:0]  low;
    wire  [5:0]  high;
    wire         en;
    wire  [1:0]  mon;
    wire         stby;
    int          failures;
    int          checked;
    logic [15:0] rsp;
    logic        nf;
    // Supply bits: over, under, thermal shutdown, thermal warning, pump off
    ldc_top #(.WAKE_CYCLES(WAKE)) ldc_top_inst (
        .clk_i(clk_i), .reset_i(reset_i), .enable_i(1'b1),
        .serial_clock_i(sclk), .chip_select_low_i(csl), .serial_input_i(sdi),
        .serial_output_o(sdo), .serial_output_oe_o(sdo_oe),
        .overcurrent_i(oc), .open_load_i(ol),
        .supply_over_i(sup[4]), .supply_under_i(sup[3]), .thermal_shutdown_i(sup[2]),
        .thermal_warning_i(sup[1]), .charge_pump_off_i(sup[0]),
        .low_side_switch_o(low), .high_side_switch_o(high), .outputs_enabled_o(en),
        .monitor_select_o(mon), .standby_o(stby));
    ldc_host_model ldc_host_model_inst (
        .clk_i(clk_i), .serial_clock_o(sclk), .chip_select_low_o(csl),
        .serial_input_o(sdi), .serial_output_i(sdo_line));
    // Released line shows the inverse, so sampling while undriven is caught
    assign sdo_line = sdo_oe ? sdo : ~sdo;
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    function automatic logic [15:0] pins();
        return {1'b0, mon, stby, en, high, low};
    endfunction
    task automatic compare(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic xfer(input logic [15:0] cmd);
        ldc_host_model_inst.xfer(cmd, rsp);
    endtask
    task automatic test_drive();
        xfer(16'h1B36);
        repeat (WAKE - 15) @(posedge clk_i);
        compare(pins(), 16'h2D54, "drive pattern");
        $display("test_drive done");
    endtask
    task automatic test_monitor();
        for (int i = 1; i < 4; i++) begin
            xfer({2'b00, i[1:0], 12'h000});
            compare(pins(), {1'b0, i[1:0], 2'b01, 11'h000}, "monitor code");
        end
        // Standby word carries switch bits that must not survive
        xfer(16'h0FFE);
        compare(pins(), 16'h1000, "standby entry");
        $display("test_monitor done");
    endtask
    task automatic test_status();
        xfer(16'h1000);
        // Faults only after wake-up, so the wake bound stays meaningful
        repeat (WAKE) @(posedge clk_i);
        oc <= 11'h009;
        ol <= 11'h401;
        sup <= 5'b10111;
        repeat (8) @(posedge clk_i);
        xfer(16'h1000);
        compare(rsp, 16'hD012, "word 0");
        xfer(16'h1001);
        compare(rsp, 16'hB802, "word 1");
        ldc_host_model_inst.poll(nf);
        compare({15'h0000, nf}, 16'h0000, "fault poll");
        oc <= 11'h000;
        ol <= 11'h000;
        sup <= 5'b00000;
        xfer(16'h9000);
        compare(rsp, 16'hD012, "word 0 before clear");
        ldc_host_model_inst.poll(nf);
        compare({15'h0000, nf}, 16'h0001, "poll after clear");
        xfer(16'h1000);
        compare(rsp, 16'h8001, "word 0 clean");
        $display("test_status done");
    endtask
    task automatic test_lockout();
        xfer(16'h5002);
        compare(pins(), 16'h2801, "lockout drive");
        sup <= 5'b01000;
        repeat (6) @(posedge clk_i);
        sup <= 5'b00000;
        repeat (10) @(posedge clk_i);
        compare(pins(), 16'h2000, "held off");
        xfer(16'hD002);
        compare(pins(), 16'h2801, "released");
        oc <= 11'h001;
        repeat (6) @(posedge clk_i);
        oc <= 11'h000;
        repeat (10) @(posedge clk_i);
        compare(pins(), 16'h2800, "overcurrent hold");
        xfer(16'h9002);
        compare(pins(), 16'h2801, "overcurrent cleared");
        sup <= 5'b01000;
        repeat (6) @(posedge clk_i);
        compare(pins(), 16'h2000, "supply fault off");
        sup <= 5'b00000;
        repeat (6) @(posedge clk_i);
        compare(pins(), 16'h2801, "supply returned");
        $display("test_lockout done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        reset_i = 1'b1;
        oc = 11'h000;
        ol = 11'h000;
        sup = 5'b00000;
        failures = 0;
        checked = 0;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        compare(pins(), 16'h1000, "reset state");
        $display("test_reset done");
        test_drive();
        test_monitor();
        test_status();
        test_lockout();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        $display("Error %0t: watchdog expired", $time);
        summarize();
    end
endmodule
`default_nettype wire
